// File: hw/fir_filter.sv
// Systolic FIR filter with output buffer and APB control registers
`timescale 1ns/1ps

// Overview of operation
// - Output is weighted sum of delayed samples
// - Weights signed, fraction bits below sign
// - Samples are signed sample_width-bit buses
// - Truncate to sample_width when not rounding
// - Round half up positive, under half negative
// - Clamp overflow to extreme of same sign
// - Without clamping keep low bits, wrap
// - Zero weights use reduced cells
// - Advance only on edges with enable high
// - Latency is taps plus stages plus four
// - Rounding stage adds two cycles
// - Saturation stage adds one cycle
// - Taps above two, sample width two+
// - Weights are fixed build-time constants
// - Chain of registered multiply-add cells
module fir_filter
  import fir_pkg::*;
#(
  parameter int NTAPS = NUM_TAPS,        // Taps used from the weight table
  parameter int SW = SAMPLE_WIDTH,       // Sample bits
  parameter int CW = COEF_WIDTH,         // Weight bits
  parameter int FB = COEF_FRAC_BITS,     // Weight fraction bits
  parameter bit RND = ROUND_SELECT,      // Rounding stage present
  parameter bit SAT = CLAMP_SELECT,      // Saturation stage present
  parameter bit PRUNE = ZERO_WEIGHT_PRUNE // Zero-weight pruning
) (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic enable_i,
  input wire logic signed [SW-1:0] sample_input_i,
  output logic sample_ready_o,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic signed [SW-1:0] sample_output_o,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  ////////////////////////////////////////////////////////////////////////////
  // Derived sizes
  localparam int ACC_W = SW + CW + $clog2(NTAPS); // Full-precision sum
  localparam int Q_W = ACC_W - FB;                // Sum without fraction
  localparam int LAT_TOT = NTAPS + (RND ? LAT_ROUND : 0) +
                           (SAT ? LAT_CLAMP : 0) + LAT_FIXED;
  localparam int PC_W = $clog2(LAT_TOT + 1);      // Prime counter bits

  // Parameter checks
  // build-time limits
  if (NTAPS <= 2 || SW < 2) begin : g_bad_shape
    $error("tap count must exceed 2 and sample width be 2 or more");
  end
  if (CW < 2 || FB < 0 || FB >= CW || CW != COEF_WIDTH) begin : g_bad_coef
    $error("weight width or fraction bits out of range");
  end
  if (NTAPS > NUM_TAPS) begin : g_bad_table
    $error("weight table shorter than tap count");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Arithmetic helpers

  // Symmetric rounding offset for the sign of a sum
  function automatic logic signed [ACC_W-1:0] round_bias(input logic neg);
    logic signed [ACC_W-1:0] half;
    half = '0;
    if (FB > 0) begin
      half = ACC_W'(1) << (FB - 1);
    end
    // No fraction bits: nothing to round, no bias either way
    return (neg && FB > 0) ? half - ACC_W'(1) : half;
  endfunction

  // Clamp a reduced sum to the sample range
  function automatic logic signed [SW-1:0] clamp_to(
      input logic signed [Q_W-1:0] v);
    logic signed [Q_W-1:0] hi;
    logic signed [Q_W-1:0] lo;
    hi = {{(Q_W-SW+1){1'b0}}, {(SW-1){1'b1}}};
    lo = ~hi;
    if (v > hi) begin
      return hi[SW-1:0];
    end else if (v < lo) begin
      return lo[SW-1:0];
    end
    return v[SW-1:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Control and flow
  logic run_q;      // Software run bit
  logic buf_ready;  // Buffer can take a word
  logic adv;        // Pipeline advances this edge
  logic primed;     // Output register holds a real result
  logic push;       // Word enters the buffer
  logic pop;        // Word leaves the buffer
  logic [PC_W-1:0] prime_q; // Advances seen, saturating

  assign adv = enable_i && run_q && buf_ready;
  assign sample_ready_o = run_q && buf_ready;
  assign primed = (prime_q == PC_W'(LAT_TOT));
  // first result after the full latency
  assign push = adv && primed;

  // Count advances until the first real output
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prime_q <= '0;
    end else if (adv && !primed) begin
      prime_q <= prime_q + PC_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Systolic array
  logic signed [SW-1:0] x_q;                 // Captured input sample
  logic signed [SW-1:0] x_ch [0:NTAPS];      // Sample chain
  logic signed [ACC_W-1:0] s_ch [0:NTAPS];   // Sum chain
  logic signed [ACC_W-1:0] s_last;           // Full-precision result

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      x_q <= '0;
    end else if (adv) begin
      x_q <= sample_input_i;
    end
  end

  assign x_ch[0] = x_q;
  assign s_ch[0] = '0;
  assign s_last = s_ch[NTAPS];

  for (genvar i = 0; i < NTAPS; i++) begin : g_tap
    mac_cell #(
      .SW(SW),
      .CW(CW),
      .AW(ACC_W),
      .WEIGHT(TAP_WEIGHTS[i]),
      .PRUNE(PRUNE)
    ) u_cell (
      .core_clk_i(core_clk_i),
      .rst_b_i(rst_b_i),
      .adv_i(adv),
      .x_i(x_ch[i]),
      .sum_i(s_ch[i]),
      .x_o(x_ch[i+1]),
      .sum_o(s_ch[i+1])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Word-length reduction
  logic signed [Q_W-1:0] red; // Sum with fraction removed

  if (RND) begin : g_rnd
    logic signed [ACC_W-1:0] r1_q; // Biased sum
    logic signed [Q_W-1:0] r2_q;   // Fraction dropped

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        r1_q <= '0;
        r2_q <= '0;
      end else if (adv) begin
        r1_q <= s_last + round_bias(s_last[ACC_W-1]);
        r2_q <= Q_W'(r1_q >>> FB);
      end
    end
    assign red = r2_q;

    // Bias follows the sign of the sum
    round_bias_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      adv |=> (r1_q - $past(s_last)) ==
        ($past(s_last[ACC_W-1]) ? round_bias(1'b1) : round_bias(1'b0)))
      else $error("rounding offset wrong for sign");

    // Biased sum leaves stage two after two advances
    round_lat_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      adv ##1 adv |=> r2_q == Q_W'(($past(s_last, 2) +
        round_bias($past(s_last[ACC_W-1], 2))) >>> FB))
      else $error("rounding stage latency wrong");
  end else begin : g_trn
    assign red = Q_W'(s_last >>> FB);
  end

  logic signed [SW-1:0] fin; // Value entering the output register

  if (SAT) begin : g_sat
    logic signed [SW-1:0] c_q; // Clamped sample

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        c_q <= '0;
      end else if (adv) begin
        c_q <= clamp_to(red);
      end
    end
    assign fin = c_q;

    // Positive overflow gives the largest sample
    clamp_high_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      adv && red > Q_W'(2 ** (SW - 1) - 1) |=>
        c_q == {1'b0, {(SW-1){1'b1}}})
      else $error("positive overflow not clamped");

    // Negative overflow gives the smallest sample
    clamp_low_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      adv && red < -Q_W'(2 ** (SW - 1)) |=> c_q == {1'b1, {(SW-1){1'b0}}})
      else $error("negative overflow not clamped");
  end else begin : g_wrap
    assign fin = red[SW-1:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output register
  logic signed [SW-1:0] y_q; // Final pipeline register

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      y_q <= '0;
    end else if (adv) begin
      y_q <= fin;
    end
  end

  // Registers stay put without an advance
  hold_out_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    !adv |=> $stable(y_q) && $stable(x_q) && $stable(s_last))
    else $error("pipeline moved without enable");

  // No advance without the upstream enable
  adv_gate_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    !enable_i |=> $stable(x_q) && $stable(prime_q))
    else $error("sample taken with enable low");

  // First result comes exactly at the latency count
  prime_push_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    push |-> prime_q == PC_W'(LAT_TOT) && $past(prime_q) >= PC_W'(LAT_TOT - 1))
    else $error("output released before latency");

  ////////////////////////////////////////////////////////////////////////////
  // Two-entry output buffer
  logic signed [SW-1:0] buf_mem [0:BUF_DEPTH-1]; // Stored samples
  logic wr_q;       // Write slot
  logic rd_q;       // Read slot
  logic [1:0] cnt_q; // Words held

  assign buf_ready = (cnt_q != 2'(BUF_DEPTH));
  assign out_valid_o = (cnt_q != 2'h0);
  assign pop = out_valid_o && out_ready_i;
  assign sample_output_o = buf_mem[rd_q];

  // Slot storage, written from the output register
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      buf_mem[0] <= '0;
      buf_mem[1] <= '0;
    end else if (push) begin
      buf_mem[wr_q] <= y_q;
    end
  end

  // Pointers and fill level
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      wr_q <= wr_q ^ push;
      rd_q <= rd_q ^ pop;
      cnt_q <= cnt_q + 2'(push) - 2'(pop);
    end
  end

  // A full buffer stalls the pipeline
  buf_stall_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    cnt_q == 2'(BUF_DEPTH) |-> !adv && !sample_ready_o)
    else $error("pipeline advanced into full buffer");

  ////////////////////////////////////////////////////////////////////////////
  // APB registers
  logic [31:0] ocnt_q; // Samples handed downstream
  logic hit;           // Address is mapped
  logic wr_acc;        // Write access phase

  assign pready = 1'b1;
  assign hit = paddr == CTRL_OFS || paddr == STAT_OFS ||
               paddr == OCNT_OFS || paddr == CFG_OFS;
  assign pslverr = psel && penable && !hit;
  assign wr_acc = psel && penable && pwrite && hit;

  // Control register
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      run_q <= CTRL_RUN_RST;
    end else if (wr_acc && paddr == CTRL_OFS) begin
      run_q <= pwdata[CTRL_RUN_BIT];
    end
  end

  // Delivered sample counter, write clears
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ocnt_q <= '0;
    end else if (wr_acc && paddr == OCNT_OFS) begin
      ocnt_q <= '0;
    end else if (pop) begin
      ocnt_q <= ocnt_q + 32'h0000_0001;
    end
  end

  // Read data, captured in the setup cycle
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prdata <= '0;
    end else if (psel && !penable) begin
      prdata <= '0;
      unique case (paddr)
        CTRL_OFS: prdata[CTRL_RUN_BIT] <= run_q;
        STAT_OFS: begin
          prdata[STAT_PRIMED_BIT] <= primed;
          prdata[STAT_FULL_BIT] <= !buf_ready;
          prdata[STAT_VALID_BIT] <= out_valid_o;
        end
        OCNT_OFS: prdata <= ocnt_q;
        CFG_OFS: begin
          prdata[CFG_TAPS_LSB+:8] <= 8'(NTAPS);
          prdata[CFG_SW_LSB+:8] <= 8'(SW);
          prdata[CFG_RND_BIT] <= RND;
          prdata[CFG_SAT_BIT] <= SAT;
          prdata[CFG_PRUNE_BIT] <= PRUNE;
        end
        default: prdata <= '0;
      endcase
    end
  end

endmodule

// File: hw/mac_cell.sv
// One registered multiply-add cell of the systolic chain
`timescale 1ns/1ps

module mac_cell
  import fir_pkg::*;
#(
  parameter int SW = SAMPLE_WIDTH,      // Sample bits
  parameter int CW = COEF_WIDTH,        // Weight bits
  parameter int AW = SAMPLE_WIDTH + COEF_WIDTH + 5, // Sum bits
  parameter logic signed [COEF_WIDTH-1:0] WEIGHT = '0, // This tap's weight
  parameter bit PRUNE = 1'b0            // Build reduced cell if weight is 0
) (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic adv_i,
  input wire logic signed [SW-1:0] x_i,
  input wire logic signed [AW-1:0] sum_i,
  output logic signed [SW-1:0] x_o,
  output logic signed [AW-1:0] sum_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Two-deep sample delay, keeps sample and sum waves aligned
  logic signed [SW-1:0] xa_q; // Sample feeding the multiplier
  logic signed [SW-1:0] xb_q; // Sample handed to the next cell

  // Sample delay pair
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      xa_q <= '0;
      xb_q <= '0;
    end else if (adv_i) begin
      xa_q <= x_i;
      xb_q <= xa_q;
    end
  end
  assign x_o = xb_q;

  ////////////////////////////////////////////////////////////////////////////
  // Product and sum stages
  if (PRUNE && WEIGHT == 0) begin : g_zero
    // reduced cell
    // Zero weight: only the sum register, same timing
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        sum_o <= '0;
      end else if (adv_i) begin
        sum_o <= sum_i;
      end
    end

    // Pass-through check
    prune_pass_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      adv_i |=> sum_o == $past(sum_i))
      else $error("pruned cell did not pass sum");
  end else begin : g_full
    logic signed [SW+CW-1:0] p_q; // Registered product

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        p_q <= '0;
        sum_o <= '0;
      end else if (adv_i) begin
        p_q <= xa_q * WEIGHT;
        sum_o <= sum_i + AW'(p_q);
      end
    end

    // Product reaches the sum two advances after the sample
    mac_sum_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      adv_i ##1 adv_i |=>
        sum_o == $past(sum_i) + $past(xa_q, 2) * WEIGHT)
      else $error("cell sum does not add product");
  end

endmodule

// File: include/fir_pkg.sv
// Shared build-time configuration of the systolic filter and its registers
package fir_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Filter shape
  localparam int NUM_TAPS = 20;           // Taps in the chain
  localparam int SAMPLE_WIDTH = 16;       // Input and output sample bits
  localparam int COEF_WIDTH = 12;         // Tap weight bits
  localparam int COEF_FRAC_BITS = 10;     // Fractional weight bits
  localparam bit ROUND_SELECT = 1'b1;     // Symmetric rounding, else truncate
  localparam bit CLAMP_SELECT = 1'b1;     // Saturate, else wrap
  localparam bit ZERO_WEIGHT_PRUNE = 1'b1; // Reduced cells for zero weights

  // Fixed tap weights, tap 0 first
  localparam logic signed [COEF_WIDTH-1:0] TAP_WEIGHTS [0:NUM_TAPS-1] = '{
    12'sh000, -12'sh006, -12'sh00C, 12'sh000, 12'sh018,
    12'sh02A, 12'sh000, -12'sh04E, -12'sh07A, 12'sh100,
    12'sh100, -12'sh07A, -12'sh04E, 12'sh000, 12'sh02A,
    12'sh018, 12'sh000, -12'sh00C, -12'sh006, 12'sh000
  };

  ////////////////////////////////////////////////////////////////////////////
  // Pipeline latency terms, in enabled cycles
  localparam int LAT_ROUND = 2;           // Rounding stage
  localparam int LAT_CLAMP = 1;           // Saturation stage
  localparam int LAT_FIXED = 4;           // Input, array tail and output regs

  ////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses
  localparam int APB_ADDR_W = 8;          // Decoded address bits
  localparam logic [7:0] CTRL_OFS = 8'h00;  // Control
  localparam logic [7:0] STAT_OFS = 8'h04;  // Live status
  localparam logic [7:0] OCNT_OFS = 8'h08;  // Delivered output samples
  localparam logic [7:0] CFG_OFS = 8'h0C;   // Build configuration

  // Field positions
  localparam int CTRL_RUN_BIT = 0;        // Pipeline may advance
  localparam int STAT_PRIMED_BIT = 0;     // Pipeline holds real outputs
  localparam int STAT_FULL_BIT = 1;       // Output buffer full
  localparam int STAT_VALID_BIT = 2;      // Output word waiting
  localparam int CFG_TAPS_LSB = 0;        // Tap count field
  localparam int CFG_SW_LSB = 8;          // Sample width field
  localparam int CFG_RND_BIT = 16;        // Rounding built in
  localparam int CFG_SAT_BIT = 17;        // Saturation built in
  localparam int CFG_PRUNE_BIT = 18;      // Pruning built in

  // Reset values
  localparam logic CTRL_RUN_RST = 1'b1;   // Filter runs out of reset

  // Output buffer depth
  localparam int BUF_DEPTH = 2;

endpackage

// File: tb/fir_partner.sv
// Sample source and consumer standing on both sides of the filter
`timescale 1ns/1ps

module fir_partner
  import fir_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic run_i,        // Source may offer samples
  input wire logic slow_i,       // Gaps in offers and consumer pauses
  input wire logic stall_i,      // Consumer refuses every word
  input wire logic [7:0] cnt_i,  // Samples to send
  input wire logic signed [SAMPLE_WIDTH-1:0] stim_i, // Value at idx_o
  input wire logic ready_i,      // Filter can take a sample
  output logic enable_o,         // Sample offered
  output logic signed [SAMPLE_WIDTH-1:0] sample_o, // Offered sample
  output logic [7:0] idx_o,      // Index of the offered sample
  output logic out_ready_o       // Consumer takes a word
);
  logic [2:0] cyc_q;  // Pacing pattern
  logic take;         // Sample accepted at this edge
  logic [7:0] nxt;    // Index after this edge

  assign take = enable_o && ready_i;
  assign nxt = idx_o + 8'(take);
  // Idle data inverted so a stale sample never looks current
  assign sample_o = enable_o ? stim_i : ~stim_i;

  ////////////////////////////////////////////////////////////////////////////
  // Pacing counter
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cyc_q <= 3'h0;
    end else begin
      cyc_q <= cyc_q + 3'h1;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      enable_o <= 1'b0;
      idx_o <= 8'h00;
    end else begin
      idx_o <= nxt;
      // Offer only changes once the held one is gone
      if (!enable_o || ready_i) begin
        enable_o <= run_i && (nxt < cnt_i) && !(slow_i && cyc_q[0]);
      end
    end
  end

  // Consumer readiness
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      out_ready_o <= 1'b0;
    end else begin
      out_ready_o <= !stall_i && !(slow_i && cyc_q[1]);
    end
  end
endmodule

// File: tb/tb.sv
// Self-checking bench for the filter in two build variants
`timescale 1ns/1ps

module tb;
  import fir_pkg::*;
  localparam int LAT0 = NUM_TAPS + LAT_ROUND + LAT_CLAMP + LAT_FIXED;
  localparam int LAT1 = NUM_TAPS + LAT_FIXED; // No round, no clamp
  localparam longint MAXV = (64'sh1 <<< (SAMPLE_WIDTH - 1)) - 1;
  logic core_clk_i = 1'b0;
  logic rst_b_i = 1'b1;
  logic run = 1'b0;
  logic slow = 1'b0;
  logic stall = 1'b0;
  logic [7:0] cnt = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [APB_ADDR_W-1:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic signed [SAMPLE_WIDTH-1:0] stim [0:255];
  logic en [2], rdy [2], vld [2], ordy [2], pready [2], pslverr [2];
  logic signed [SAMPLE_WIDTH-1:0] din [2], dout [2];
  logic signed [SAMPLE_WIDTH-1:0] got [2][$];
  logic [7:0] idx [2];
  logic [31:0] prdata [2];
  int adv [2], first [2];
  int err_total = 0;
  int n_checks = 0;

  always #12.5 core_clk_i = ~core_clk_i;

  ////////////////////////////////////////////////////////////////////////////
  // Variant 0 rounds, clamps, prunes; variant 1 does none
  for (genvar g = 0; g < 2; g++) begin : cfg
    fir_filter #(.RND(g == 0), .SAT(g == 0), .PRUNE(g == 0)) fir_filter_i (
      .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .enable_i(en[g]),
      .sample_input_i(din[g]), .sample_ready_o(rdy[g]),
      .out_valid_o(vld[g]), .out_ready_i(ordy[g]),
      .sample_output_o(dout[g]), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata[g]), .pready(pready[g]), .pslverr(pslverr[g]));
    fir_partner fir_partner_i (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
      .run_i(run), .slow_i(slow), .stall_i(stall), .cnt_i(cnt),
      .stim_i(stim[idx[g]]), .ready_i(rdy[g]), .enable_o(en[g]),
      .sample_o(din[g]), .idx_o(idx[g]), .out_ready_o(ordy[g]));
  end

  // Advance count at first output, and popped words
  always @(posedge core_clk_i) begin
    for (int g = 0; g < 2; g++) begin
      if (vld[g] === 1'b1 && first[g] < 0) first[g] = adv[g];
      if (en[g] && rdy[g]) adv[g]++;
      if (vld[g] && ordy[g]) got[g].push_back(dout[g]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare and report
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // One APB transfer to both variants
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r0, output logic [31:0] r1,
      output logic e);
    @(posedge core_clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk_i);
    penable <= 1'b1;
    do begin
      @(posedge core_clk_i);
    end while (!(pready[0] === 1'b1 && pready[1] === 1'b1));
    r0 = prdata[0];
    r1 = prdata[1];
    e = pslverr[0];
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Expected output for input n
  function automatic logic signed [SAMPLE_WIDTH-1:0] model(int n, logic rs);
    longint acc = 0;
    for (int j = 0; j < NUM_TAPS; j++)
      if (n >= j) acc += longint'(TAP_WEIGHTS[j]) * longint'(stim[n - j]);
    // Half up when positive, just under half when negative
    if (rs) acc += (64'sh1 <<< (COEF_FRAC_BITS - 1)) - (acc < 0 ? 1 : 0);
    acc = acc >>> COEF_FRAC_BITS;
    if (rs && acc > MAXV) acc = MAXV;
    if (rs && acc < -MAXV - 1) acc = -MAXV - 1;
    return acc[SAMPLE_WIDTH-1:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers, read-only places, unmapped address, run bit
  task automatic t_regs();
    logic [31:0] r0, r1, c0;
    logic e;
    c0 = NUM_TAPS | (SAMPLE_WIDTH << CFG_SW_LSB);
    apb(1'b0, STAT_OFS, 32'h0, r0, r1, e);
    check("stat reset", r0, 32'h0);
    apb(1'b1, CFG_OFS, 32'h0, r0, r1, e);
    apb(1'b0, CFG_OFS, 32'h0, r0, r1, e);
    check("cfg 0", r0, c0 | (32'h7 << CFG_RND_BIT));
    check("cfg 1", r1, c0);
    apb(1'b0, 8'h10, 32'h0, r0, r1, e);
    check("unmapped err", e, 1'b1);
    check("unmapped data", r0, 32'h0);
    apb(1'b0, CTRL_OFS, 32'h0, r0, r1, e);
    check("ctrl reset", r0, 32'(CTRL_RUN_RST));
    apb(1'b1, CTRL_OFS, 32'h0, r0, r1, e);
    @(posedge core_clk_i);
    check("run off", rdy[0], 1'b0);
    apb(1'b1, CTRL_OFS, 32'h1, r0, r1, e);
    @(posedge core_clk_i);
    check("run on", rdy[0], 1'b1);
    $display("test regs done");
  endtask

  // Stream n samples from reset, optionally paced and stalled
  task automatic run_stream(int n, logic sl);
    logic [31:0] r0, r1;
    logic signed [SAMPLE_WIDTH-1:0] held;
    logic e;
    rst_b_i <= 1'b0;
    cnt <= 8'(n);
    slow <= sl;
    for (int g = 0; g < 2; g++) begin
      got[g].delete();
      adv[g] = 0;
      first[g] = -1;
    end
    repeat (3) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    run <= 1'b1;
    if (sl) begin
      repeat (90) @(posedge core_clk_i);
      stall <= 1'b1;
      repeat (30) @(posedge core_clk_i);
      held = dout[0];
      repeat (10) @(posedge core_clk_i);
      check("stall ready", rdy[0], 1'b0);
      check("stall valid", vld[0], 1'b1);
      check("stall hold", dout[0], held);
      // Both variants primed, full and holding a word
      apb(1'b0, STAT_OFS, 32'h0, r0, r1, e);
      check("stall stat 0", r0, 32'((1 << STAT_VALID_BIT) |
          (1 << STAT_FULL_BIT) | (1 << STAT_PRIMED_BIT)));
      check("stall stat 1", r1, r0);
      stall <= 1'b0;
    end
    // Wait until both variants have delivered their expected words; the watchdog stops a hang
    while (got[0].size() < n - LAT0 || got[1].size() < n - LAT1) begin
      @(posedge core_clk_i);
    end
    check("latency 0", first[0], LAT0 + 1);
    check("latency 1", first[1], LAT1 + 1);
    for (int g = 0; g < 2; g++)
      for (int i = 0; i < got[g].size(); i++)
        check("sample", got[g][i], model(i, g == 0));
    apb(1'b0, OCNT_OFS, 32'h0, r0, r1, e);
    check("count 0", r0, n - LAT0);
    check("count 1", r1, n - LAT1);
    // Any write clears the delivered count
    apb(1'b1, OCNT_OFS, 32'h0, r0, r1, e);
    apb(1'b0, OCNT_OFS, 32'h0, r0, r1, e);
    check("count clear", r0, 32'h0);
    run <= 1'b0;
    slow <= 1'b0;
  endtask

  // Impulses: tap weights, rounding of both signs
  task automatic t_impulse();
    for (int k = 0; k < 256; k++)
      stim[k] = 16'sh0000;
    stim[0] = 16'sh0100;
    stim[25] = -16'sh0300;
    stim[50] = 16'sh7FFF;
    run_stream(80, 1'b0);
    $display("test impulse done");
  endtask

  // Overflow both ways, then mixed data, with gaps and a full stall
  task automatic t_stress();
    for (int k = 0; k < 256; k++) begin
      if (k >= 2 * NUM_TAPS || TAP_WEIGHTS[k % NUM_TAPS] == 0)
        stim[k] = 16'(k * 16'h1357);
      else if ((k < NUM_TAPS) == (TAP_WEIGHTS[k % NUM_TAPS] > 0))
        stim[k] = 16'sh7FFF;
      else
        stim[k] = 16'sh8000;
    end
    run_stream(100, 1'b1);
    $display("test stress done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst_b_i = 1'b0;
    repeat (3) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    t_regs();
    t_impulse();
    t_stress();
    complete_run();
  end

  // Watchdog
  initial begin
    repeat (20000) @(posedge core_clk_i);
    err_total++;
    complete_run();
  end
endmodule
